// *** logic/gpio_params.svh ***
// Register indices, field positions and reset values for the parallel I/O block
`ifndef GPIO_PARAMS_SVH
`define GPIO_PARAMS_SVH

// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define IDX_PORT_F_DIRECTION 8'h03
`define IDX_PORT_F_VALUE 8'h05
`define IDX_PORT_C_DIRECTION 8'h07
`define IDX_PORT_D_VALUE 8'h08
`define IDX_PORT_D_DIRECTION 8'h09
`define IDX_PORT_E_INPUT_VALUE 8'h0a
`define IDX_RESISTOR_ASSIGN 8'h2c
`define IDX_OUTPUT_OPTIONS 8'h38
`define IDX_RESISTOR_GATE 8'h3f
`define IDX_PORT_H_VALUE 8'h7c
`define IDX_PORT_H_DIRECTION 8'h7d
`define IDX_PORT_G_VALUE 8'h7e
`define IDX_PORT_G_DIRECTION 8'h7f

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define BIT_PORTB_PULLUP 0
`define BIT_PORT_F_VALUE_PULLUP 1
`define BIT_PORT_G_VALUE_PULLUP 2
`define BIT_PORT_H_VALUE_RESISTOR 3
`define BIT_PORTC_OPEN_DRAIN 6
`define BIT_RESISTOR_GATE 4
`define BIT_RW_STROBE 7
`define PORT_D_WIDTH 6

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RST_DIRECTION 8'h00
`define RST_RESISTOR_ASSIGN 4'hf
`define RST_RESISTOR_GATE 1'b1
`define RST_OPEN_DRAIN 1'b0

// ------------------------------------------------------------
// AXI responses
// ------------------------------------------------------------
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// *** logic/gpio_pkg.sv ***
// Types shared by the parallel I/O block and its pin cell
package gpio_pkg;

	// ------------------------------------------------------------
	// Pin drive bundle for one 8-bit port
	// ------------------------------------------------------------
	typedef struct packed
	{
		logic [7:0] value;
		logic [7:0] enable;
		logic [7:0] pull_up;
		logic [7:0] pull_down;
	} pin_drive_t;

	// Alternate function request from a peripheral
	typedef struct packed
	{
		logic [7:0] select;
		logic [7:0] value;
		logic [7:0] enable;
	} alt_func_t;

endpackage

// *** logic/parallel_io_ports.sv ***
// Parallel I/O ports C (direction) to H with an AXI4-Lite register slave
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "gpio_params.svh"
module parallel_io_ports
	import gpio_pkg::*;
#(
	parameter int ADDR_WIDTH = 12
)
(
	input wire logic aclk, // System clock, 20 MHz
	input wire logic aresetn, // Synchronous reset, active low
	// AXI4-Lite slave
	input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [ADDR_WIDTH-1:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	// Operating mode and bus takeover
	input wire logic expanded_mode, // High in expanded or test mode
	input wire logic [7:0] address_low, // Low address for port F
	input wire logic rw_strobe, // Read/write strobe for port G pin 7
	input wire logic [7:0] port_c_out_value, // Port C data from its register
	// Peripheral alternate functions
	input alt_func_t port_d_alt, // Serial 1 and SPI requests
	input alt_func_t port_h_alt, // PWM and serial 2/3 requests
	// Pin levels, synchronous to aclk
	input wire logic [7:0] port_c_pin_in, // Port C pin levels
	input wire logic [7:0] port_d_pin_in, // Port D pin levels
	input wire logic [7:0] port_e_pin_in, // Port E pin levels
	input wire logic [7:0] port_f_pin_in, // Port F pin levels
	input wire logic [7:0] port_g_pin_in, // Port G pin levels
	input wire logic [7:0] port_h_pin_in, // Port H pin levels
	// Pin drive
	output pin_drive_t port_c_pins, // Port C drive
	output pin_drive_t port_d_pins, // Port D drive
	output pin_drive_t port_f_pins, // Port F drive
	output pin_drive_t port_g_pins, // Port G drive
	output pin_drive_t port_h_pins, // Port H drive
	output logic portb_pull_active // Port B pull-ups on
);

	// ------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------
	logic [7:0] port_c_direction_reg;
	logic [`PORT_D_WIDTH-1:0] port_d_direction_reg;
	logic [7:0] port_f_direction_reg;
	logic [7:0] port_g_direction_reg;
	logic [7:0] port_h_direction_reg;
	logic [`PORT_D_WIDTH-1:0] port_d_value_reg;
	logic [7:0] port_f_value_reg;
	logic [7:0] port_g_value_reg;
	logic [7:0] port_h_value_reg;
	logic [3:0] resistor_assign_reg;
	logic resistor_assign_gate_reg;
	logic portc_open_drain_sel_reg;

	// Bus side state
	logic [ADDR_WIDTH-1:0] wr_addr_reg;
	logic [7:0] wr_data_reg;
	logic wr_strobe_reg;
	logic [7:0] rd_data_next;
	logic rd_hit_next;
	logic wr_hit;
	logic do_write;
	logic do_read;
	logic [7:0] wr_index;
	logic [7:0] rd_index;

	// ------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------
	// Index from a byte address; upper bits beyond the map must be zero
	function automatic logic [7:0] reg_index(input logic [ADDR_WIDTH-1:0] addr);
		logic [ADDR_WIDTH-1:0] word;
		word = addr >> 2;
		if (word > ADDR_WIDTH'(8'hff))
		begin
			reg_index = 8'h00;
		end
		else
		begin
			reg_index = word[7:0];
		end
	endfunction

	// Index is mapped in the current operating mode
	function automatic logic reg_mapped(input logic [7:0] idx, input logic expanded);
		case (idx)
			`IDX_PORT_F_DIRECTION, `IDX_PORT_F_VALUE, `IDX_PORT_C_DIRECTION:
				reg_mapped = !expanded;
			`IDX_PORT_D_VALUE, `IDX_PORT_D_DIRECTION, `IDX_PORT_E_INPUT_VALUE,
			`IDX_RESISTOR_ASSIGN, `IDX_OUTPUT_OPTIONS, `IDX_RESISTOR_GATE,
			`IDX_PORT_H_VALUE, `IDX_PORT_H_DIRECTION,
			`IDX_PORT_G_VALUE, `IDX_PORT_G_DIRECTION:
				reg_mapped = 1'b1;
			default:
				reg_mapped = 1'b0;
		endcase
	endfunction

	// Output bits read back stored data, input bits read the pin
	function automatic logic [7:0] pin_view(input logic [7:0] stored, input logic [7:0] dir,
		input logic [7:0] pin);
		pin_view = (dir & stored) | (~dir & pin);
	endfunction

	// ------------------------------------------------------------
	// Write channel handshake
	// ------------------------------------------------------------
	// Address and data are taken in either order; ready drops until the response
	assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign wr_index = reg_index(wr_addr_reg);
	assign wr_hit = reg_mapped(wr_index, expanded_mode);

	// Write address capture
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b1;
			wr_addr_reg <= '0;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			s_axi_awready <= 1'b0;
			wr_addr_reg <= s_axi_awaddr;
		end
		else if (s_axi_bvalid && s_axi_bready)
		begin
			s_axi_awready <= 1'b1;
		end
	end

	// Write data capture; only the low byte lane carries register data
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_wready <= 1'b1;
			wr_data_reg <= 8'h00;
			wr_strobe_reg <= 1'b0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			s_axi_wready <= 1'b0;
			wr_data_reg <= s_axi_wdata[7:0];
			wr_strobe_reg <= s_axi_wstrb[0];
		end
		else if (s_axi_bvalid && s_axi_bready)
		begin
			s_axi_wready <= 1'b1;
		end
	end

	// Write response; unmapped or removed registers answer with an error
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end
		else if (do_write)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
		end
		else if (s_axi_bready)
		begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Control registers with reset
	// ------------------------------------------------------------
	// Directions clear so every pin comes up high impedance unless expanded mode or an alternate function takes it
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			port_c_direction_reg <= `RST_DIRECTION;
			port_d_direction_reg <= `PORT_D_WIDTH'(`RST_DIRECTION);
			port_f_direction_reg <= `RST_DIRECTION;
			port_g_direction_reg <= `RST_DIRECTION;
			port_h_direction_reg <= `RST_DIRECTION;
		end
		else if (do_write && wr_hit && wr_strobe_reg)
		begin
			case (wr_index)
				`IDX_PORT_C_DIRECTION: port_c_direction_reg <= wr_data_reg;
				`IDX_PORT_D_DIRECTION: port_d_direction_reg <= wr_data_reg[`PORT_D_WIDTH-1:0];
				`IDX_PORT_F_DIRECTION: port_f_direction_reg <= wr_data_reg;
				`IDX_PORT_G_DIRECTION: port_g_direction_reg <= wr_data_reg;
				`IDX_PORT_H_DIRECTION: port_h_direction_reg <= wr_data_reg;
				default: ;
			endcase
		end
	end

	// Pull assignment, gate and port C output option
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			resistor_assign_reg <= `RST_RESISTOR_ASSIGN;
			resistor_assign_gate_reg <= `RST_RESISTOR_GATE;
			portc_open_drain_sel_reg <= `RST_OPEN_DRAIN;
		end
		else if (do_write && wr_hit && wr_strobe_reg)
		begin
			case (wr_index)
				`IDX_RESISTOR_ASSIGN: resistor_assign_reg <= wr_data_reg[3:0];
				`IDX_RESISTOR_GATE: resistor_assign_gate_reg <= wr_data_reg[`BIT_RESISTOR_GATE];
				`IDX_OUTPUT_OPTIONS: portc_open_drain_sel_reg <= wr_data_reg[`BIT_PORTC_OPEN_DRAIN];
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Data registers, no reset
	// ------------------------------------------------------------
	// Deliberately outside reset so contents survive it; start value unknown
	always_ff @(posedge aclk)
	begin
		if (do_write && wr_hit && wr_strobe_reg)
		begin
			case (wr_index)
				`IDX_PORT_D_VALUE: port_d_value_reg <= wr_data_reg[`PORT_D_WIDTH-1:0];
				`IDX_PORT_F_VALUE: port_f_value_reg <= wr_data_reg;
				`IDX_PORT_G_VALUE: port_g_value_reg <= wr_data_reg;
				`IDX_PORT_H_VALUE: port_h_value_reg <= wr_data_reg;
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Read channel
	// ------------------------------------------------------------
	assign do_read = s_axi_arvalid && s_axi_arready;
	assign rd_index = reg_index(s_axi_araddr);

	// Read decode; port E samples pins directly, so reads need no storage
	always_comb
	begin
		rd_hit_next = reg_mapped(rd_index, expanded_mode);
		rd_data_next = 8'h00;
		case (rd_index)
			`IDX_PORT_C_DIRECTION: rd_data_next = port_c_direction_reg;
			`IDX_PORT_D_DIRECTION: rd_data_next = {2'b00, port_d_direction_reg};
			`IDX_PORT_D_VALUE:
				rd_data_next = pin_view({2'b00, port_d_value_reg}, {2'b00, port_d_direction_reg},
					{2'b00, port_d_pin_in[`PORT_D_WIDTH-1:0]});
			`IDX_PORT_E_INPUT_VALUE: rd_data_next = port_e_pin_in;
			`IDX_PORT_F_DIRECTION: rd_data_next = port_f_direction_reg;
			`IDX_PORT_F_VALUE: rd_data_next = pin_view(port_f_value_reg, port_f_direction_reg, port_f_pin_in);
			`IDX_PORT_G_DIRECTION: rd_data_next = port_g_direction_reg;
			`IDX_PORT_G_VALUE: rd_data_next = pin_view(port_g_value_reg, port_g_direction_reg, port_g_pin_in);
			`IDX_PORT_H_DIRECTION: rd_data_next = port_h_direction_reg;
			`IDX_PORT_H_VALUE: rd_data_next = pin_view(port_h_value_reg, port_h_direction_reg, port_h_pin_in);
			`IDX_RESISTOR_ASSIGN: rd_data_next = {4'h0, resistor_assign_reg};
			`IDX_RESISTOR_GATE: rd_data_next = 8'(resistor_assign_gate_reg) << `BIT_RESISTOR_GATE;
			`IDX_OUTPUT_OPTIONS: rd_data_next = 8'(portc_open_drain_sel_reg) << `BIT_PORTC_OPEN_DRAIN;
			default: rd_data_next = 8'h00;
		endcase
		if (!rd_hit_next)
		begin
			rd_data_next = 8'h00;
		end
	end

	// Read address ready drops until the data has been taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
		end
		else if (do_read)
		begin
			s_axi_arready <= 1'b0;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_arready <= 1'b1;
		end
	end

	// Read data one cycle after the address is taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RESP_OKAY;
		end
		else if (do_read)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h00_0000, rd_data_next};
			s_axi_rresp <= rd_hit_next ? `RESP_OKAY : `RESP_SLVERR;
		end
		else if (s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Pull resistor enables
	// ------------------------------------------------------------
	logic pull_f;
	logic pull_g;
	logic pull_h;

	// Gate overrides every per-port enable; port F pulls only make sense off-bus
	assign pull_f = resistor_assign_gate_reg && resistor_assign_reg[`BIT_PORT_F_VALUE_PULLUP] && !expanded_mode;
	assign pull_g = resistor_assign_gate_reg && resistor_assign_reg[`BIT_PORT_G_VALUE_PULLUP];
	assign pull_h = resistor_assign_gate_reg && resistor_assign_reg[`BIT_PORT_H_VALUE_RESISTOR];

	// Port B pins live elsewhere; only their pull enable is produced here
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			portb_pull_active <= 1'b0;
		end
		else
		begin
			portb_pull_active <= resistor_assign_gate_reg && resistor_assign_reg[`BIT_PORTB_PULLUP];
		end
	end

	// ------------------------------------------------------------
	// Pin cells
	// ------------------------------------------------------------
	// Port C: no alternate here; data bus takeover is handled upstream
	port_pin_cell #(.WIDTH(8)) cell_c
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.gpio_value(port_c_out_value),
		.gpio_dir(port_c_direction_reg),
		.alt_select(8'h00),
		.alt_value(8'h00),
		.alt_enable(8'h00),
		.open_drain(portc_open_drain_sel_reg),
		.pull_up_en(8'h00),
		.pull_down_en(8'h00),
		.pins(port_c_pins)
	);

	// Port D: serial 1 on pins 1:0, SPI on pins 5:2; top two pins absent
	port_pin_cell #(.WIDTH(8)) cell_d
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.gpio_value({2'b00, port_d_value_reg}),
		.gpio_dir({2'b00, port_d_direction_reg}),
		.alt_select({2'b00, port_d_alt.select[`PORT_D_WIDTH-1:0]}),
		.alt_value(port_d_alt.value),
		.alt_enable({2'b00, port_d_alt.enable[`PORT_D_WIDTH-1:0]}),
		.open_drain(1'b0),
		.pull_up_en(8'h00),
		.pull_down_en(8'h00),
		.pins(port_d_pins)
	);

	// Port F: low address outputs in expanded mode
	port_pin_cell #(.WIDTH(8)) cell_f
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.gpio_value(port_f_value_reg),
		.gpio_dir(port_f_direction_reg),
		.alt_select({8{expanded_mode}}),
		.alt_value(address_low),
		.alt_enable(8'hff),
		.open_drain(1'b0),
		.pull_up_en({8{pull_f}}),
		.pull_down_en(8'h00),
		.pins(port_f_pins)
	);

	// Port G: pin 7 becomes the read/write strobe in expanded mode
	port_pin_cell #(.WIDTH(8)) cell_g
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.gpio_value(port_g_value_reg),
		.gpio_dir(port_g_direction_reg),
		.alt_select(8'(expanded_mode) << `BIT_RW_STROBE),
		.alt_value(8'(rw_strobe) << `BIT_RW_STROBE),
		.alt_enable(8'h80),
		.open_drain(1'b0),
		.pull_up_en({8{pull_g}}),
		.pull_down_en(8'h00),
		.pins(port_g_pins)
	);

	// Port H: PWM on 3:0, serial 2 on 5:4, serial 3 on 7:6
	port_pin_cell #(.WIDTH(8)) cell_h
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.gpio_value(port_h_value_reg),
		.gpio_dir(port_h_direction_reg),
		.alt_select(port_h_alt.select),
		.alt_value(port_h_alt.value),
		.alt_enable(port_h_alt.enable),
		.open_drain(1'b0),
		.pull_up_en({{4{pull_h}}, 4'h0}),
		.pull_down_en({4'h0, {4{pull_h}}}),
		.pins(port_h_pins)
	);

endmodule

// *** logic/port_pin_cell.sv ***
// Registered pin driver for one port: alternate takeover, open drain, pulls
`timescale 1ns/10ps
module port_pin_cell
	import gpio_pkg::*;
#(
	parameter int WIDTH = 8
)
(
	input wire logic aclk, // System clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic [WIDTH-1:0] gpio_value, // Stored data bits
	input wire logic [WIDTH-1:0] gpio_dir, // Direction bits, 1 drives
	input wire logic [WIDTH-1:0] alt_select, // Alternate function owns pin
	input wire logic [WIDTH-1:0] alt_value, // Alternate output level
	input wire logic [WIDTH-1:0] alt_enable, // Alternate output enable
	input wire logic open_drain, // Drive low only
	input wire logic [WIDTH-1:0] pull_up_en, // Pull-up allowed
	input wire logic [WIDTH-1:0] pull_down_en, // Pull-down allowed
	output pin_drive_t pins // Registered pin drive
);

	logic [WIDTH-1:0] val_next;
	logic [WIDTH-1:0] oe_next;

	// ------------------------------------------------------------
	// Pin source selection
	// ------------------------------------------------------------
	// Alternate function wins; data bits then only matter when released
	always_comb
	begin
		val_next = (alt_select & alt_value) | (~alt_select & gpio_value);
		oe_next = (alt_select & alt_enable) | (~alt_select & gpio_dir);
		if (open_drain)
		begin
			oe_next = oe_next & ~val_next;
		end
	end

	// Registered so every pin leaves the block from a flop
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pins <= '0;
		end
		else
		begin
			pins.value <= 8'(val_next);
			pins.enable <= 8'(oe_next);
			pins.pull_up <= 8'(pull_up_en & ~oe_next);
			pins.pull_down <= 8'(pull_down_en & ~oe_next);
		end
	end

endmodule

// *** test/parallel_io_ports_asserts.sv ***
// Concurrent checks on the parallel I/O block ports
`timescale 1ns/10ps
module parallel_io_ports_asserts
	import gpio_pkg::*;
(
	input wire logic aclk, // Clock
	input wire logic aresetn, // Reset, active low
	input wire logic expanded_mode, // Mode
	input wire logic [7:0] address_low, // Low address
	input wire logic rw_strobe, // Strobe level
	input wire alt_func_t port_d_alt, // Port D takeover
	input wire logic s_axi_awvalid, // AW valid
	input wire logic s_axi_awready, // AW ready
	input wire logic s_axi_wvalid, // W valid
	input wire logic s_axi_wready, // W ready
	input wire logic s_axi_bvalid, // B valid
	input wire logic s_axi_arvalid, // AR valid
	input wire logic s_axi_arready, // AR ready
	input wire logic s_axi_rvalid, // R valid
	input wire logic [31:0] s_axi_rdata, // R data
	input wire pin_drive_t port_d_pins, // Port D drive
	input wire pin_drive_t port_f_pins, // Port F drive
	input wire pin_drive_t port_g_pins, // Port G drive
	input wire pin_drive_t port_h_pins // Port H drive
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Port D, G and H pins come out of reset undriven
	property p_dir_reset; $rose(aresetn) |-> (port_d_pins.enable | port_g_pins.enable | port_h_pins.enable) == 8'h00; endproperty
	a_dir_reset: assert property (p_dir_reset) else $error("pin driven at reset release");
	property p_d_upper; port_d_pins.enable[7:6] == 2'b00; endproperty
	a_d_upper: assert property (p_d_upper) else $error("port D upper pins driven");
	property p_f_exp; expanded_mode |=> port_f_pins.enable == 8'hff && port_f_pins.value == $past(address_low); endproperty
	a_f_exp: assert property (p_f_exp) else $error("port F not on low address");
	property p_strobe; expanded_mode |=> port_g_pins.enable[7] && port_g_pins.value[7] == $past(rw_strobe); endproperty
	a_strobe: assert property (p_strobe) else $error("strobe pin wrong");
	property p_f_pull_exp; expanded_mode |=> port_f_pins.pull_up == 8'h00; endproperty
	a_f_pull_exp: assert property (p_f_pull_exp) else $error("port F pulls on in expanded mode");
	// Port H pull kind is fixed per half
	property p_h_split; port_h_pins.pull_down[7:4] == 4'h0 && port_h_pins.pull_up[3:0] == 4'h0; endproperty
	a_h_split: assert property (p_h_split) else $error("port H pull kind wrong");
	property p_pull_driven; (port_g_pins.pull_up & port_g_pins.enable) == 8'h00; endproperty
	a_pull_driven: assert property (p_pull_driven) else $error("pull on driven pin");
	property p_d_alt; port_d_alt.select[1] |=> port_d_pins.value[1] == $past(port_d_alt.value[1]); endproperty
	a_d_alt: assert property (p_d_alt) else $error("takeover value not on pin");
	property p_b_answer; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid; endproperty
	a_b_answer: assert property (p_b_answer) else $error("write response late");
	property p_r_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0; endproperty
	a_r_answer: assert property (p_r_answer) else $error("read answer late or wide");
endmodule

// *** test/parallel_io_ports_bench.sv ***
// Self-checking bench for the parallel I/O block
`timescale 1ns/10ps
`include "gpio_params.svh"
module parallel_io_ports_bench;
	import gpio_pkg::*;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, portb_pull_active;
	logic expanded_mode, rw_strobe;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [7:0] address_low, port_c_out_value, ext, port_e_pin_in;
	logic [7:0] port_c_pin_in, port_d_pin_in, port_f_pin_in, port_g_pin_in, port_h_pin_in;
	alt_func_t port_d_alt, port_h_alt;
	pin_drive_t port_c_pins, port_d_pins, port_f_pins, port_g_pins, port_h_pins;
	int num_errors = 0;
	int n_compared = 0;
	int cycles = 0;
	logic [7:0] dirs [5] = '{8'h03, 8'h07, 8'h09, 8'h7d, 8'h7f};

	parallel_io_ports u_dut (.*);
	pin_partner u_pc (.drv(port_c_pins), .ext(ext), .lvl(port_c_pin_in));
	pin_partner u_pd (.drv(port_d_pins), .ext(ext), .lvl(port_d_pin_in));
	pin_partner u_pf (.drv(port_f_pins), .ext(ext), .lvl(port_f_pin_in));
	pin_partner u_pg (.drv(port_g_pins), .ext(ext), .lvl(port_g_pin_in));
	pin_partner u_ph (.drv(port_h_pins), .ext(ext), .lvl(port_h_pin_in));

	// ----------------------------------------
	// Checking and bus tasks
	// ----------------------------------------
	task chk(input logic [33:0] got, input logic [33:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			num_errors++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task end_sim;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task settle;
		repeat (2) @(posedge aclk);
	endtask
	// Both write channels offered together, each dropped once taken
	task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] r);
		logic a, w;
		a = 1'b1;
		w = 1'b1;
		@(posedge aclk);
		s_axi_awaddr <= {2'b00, i, 2'b00};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (a | w)
		begin
			@(posedge aclk);
			a = a & (s_axi_awready !== 1'b1);
			w = w & (s_axi_wready !== 1'b1);
			s_axi_awvalid <= a;
			s_axi_wvalid <= w;
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, r);
	endtask
	task automatic rd(input logic [7:0] i, input logic [7:0] d, input logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= {2'b00, i, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk({s_axi_rresp, s_axi_rdata}, {r, 24'h0, d});
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_reset;
		settle;
		chk(port_h_pins.pull_up, 8'hf0);
		chk(port_h_pins.pull_down, 8'h0f);
		chk(port_f_pins.pull_up, 8'hff);
		chk(port_g_pins.pull_up[6:0], 7'h7f);
		chk({port_d_pins.enable, port_h_pins.enable}, 16'h0);
		chk(portb_pull_active, 1'b1);
		foreach (dirs[k]) rd(dirs[k], 8'h00, `RESP_OKAY);
		rd(8'h0a, port_e_pin_in, `RESP_OKAY);
		$display("reset test done");
	endtask
	task t_port_d;
		wr(8'h09, 8'hff, `RESP_OKAY);
		rd(8'h09, 8'h3f, `RESP_OKAY);
		wr(8'h08, 8'hd5, `RESP_OKAY);
		settle;
		chk({port_d_pins.enable, port_d_pins.value[5:0]}, {8'h3f, 6'h15});
		wr(8'h09, 8'h0f, `RESP_OKAY);
		rd(8'h08, {2'b00, ext[5:4], 4'h5}, `RESP_OKAY);
		port_d_alt <= '{8'h02, 8'h02, 8'h02};
		settle;
		chk(port_d_pins.value[1], 1'b1);
		port_d_alt <= '0;
		$display("port D test done");
	endtask
	task t_port_h;
		wr(8'h7d, 8'hff, `RESP_OKAY);
		port_h_alt <= '{8'h01, 8'h01, 8'h01};
		wr(8'h7c, 8'hfe, `RESP_OKAY);
		settle;
		chk(port_h_pins.value, 8'hff);
		rd(8'h7c, 8'hfe, `RESP_OKAY);
		s_axi_wstrb <= 4'h0;
		wr(8'h7c, 8'h00, `RESP_OKAY);
		s_axi_wstrb <= 4'h1;
		rd(8'h7c, 8'hfe, `RESP_OKAY);
		port_h_alt <= '0;
		wr(8'h7d, 8'h00, `RESP_OKAY);
		$display("port H test done");
	endtask
	task t_pulls;
		wr(`IDX_RESISTOR_GATE, 8'h00, `RESP_OKAY);
		settle;
		chk({port_f_pins.pull_up, port_g_pins.pull_up, portb_pull_active}, 17'h0);
		wr(`IDX_RESISTOR_GATE, 8'h10, `RESP_OKAY);
		wr(`IDX_RESISTOR_ASSIGN, 8'h0d, `RESP_OKAY);
		settle;
		chk({port_f_pins.pull_up, port_g_pins.pull_up[6:0], portb_pull_active}, {8'h00, 7'h7f, 1'b1});
		wr(`IDX_RESISTOR_ASSIGN, 8'h0f, `RESP_OKAY);
		$display("pull test done");
	endtask
	task t_port_c;
		wr(8'h07, 8'hff, `RESP_OKAY);
		settle;
		chk({port_c_pins.enable, port_c_pins.value}, {8'hff, port_c_out_value});
		wr(`IDX_OUTPUT_OPTIONS, 8'h40, `RESP_OKAY);
		settle;
		chk(port_c_pins.enable, 8'(~port_c_out_value));
		wr(`IDX_OUTPUT_OPTIONS, 8'h00, `RESP_OKAY);
		$display("port C test done");
	endtask
	task t_expanded;
		expanded_mode <= 1'b1;
		settle;
		chk({port_f_pins.enable, port_f_pins.value}, {8'hff, address_low});
		chk(port_g_pins.value[7], rw_strobe);
		rd(8'h03, 8'h00, `RESP_SLVERR);
		rd(8'h05, 8'h00, `RESP_SLVERR);
		rd(8'h40, 8'h00, `RESP_SLVERR);
		expanded_mode <= 1'b0;
		$display("expanded test done");
	endtask

	// ----------------------------------------
	// Clock, main sequence, timeout
	// ----------------------------------------
	initial
	begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	initial
	begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, expanded_mode} = '0;
		s_axi_wstrb = 4'h1;
		{address_low, rw_strobe, port_c_out_value} = {8'h3c, 1'b1, 8'hf0};
		{port_d_alt, port_h_alt} = '0;
		{ext, port_e_pin_in} = {8'h5a, 8'h96};
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		t_port_d;
		t_port_h;
		t_pulls;
		t_port_c;
		t_expanded;
		end_sim;
	end
	// Cut a hung handshake short
	always @(posedge aclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			num_errors = num_errors + 1;
			end_sim;
		end
	end
endmodule
bind parallel_io_ports parallel_io_ports_asserts u_chk (.*);

// *** test/pin_partner.sv ***
// External circuitry on one port: drives every pin the block leaves undriven
`timescale 1ns/10ps
module pin_partner
	import gpio_pkg::*;
(
	input wire pin_drive_t drv, // Block drive
	input wire logic [7:0] ext, // External levels
	output logic [7:0] lvl // Resolved pin level
);
	// Block wins where it drives; no conversion here, so reads never disturb one
	assign lvl = (drv.enable & drv.value) | (~drv.enable & ext);
endmodule
